/* rtl/ptc_params.svh */
// constants for the periodic tick counter
`ifndef PTC_PARAMS_SVH
`define PTC_PARAMS_SVH
`define PTC_WIDTH_DEFAULT 16
`define PTC_FLAG_RESET 1'b1
`endif

/* rtl/ptc_pkg.sv */
// types for the periodic tick counter
`default_nettype none
package ptc_pkg;
    typedef enum logic [1:0] {
        PTC_OP_HOLD = 2'b00,
        PTC_OP_LOAD = 2'b01,
        PTC_OP_UP = 2'b10,
        PTC_OP_DOWN = 2'b11
    } ptc_op_t;

    typedef enum logic [0:0] {
        PTC_ST_IDLE = 1'b0,
        PTC_ST_RUN = 1'b1
    } ptc_state_t;
endpackage
`default_nettype wire

/* rtl/ptc_periodic_tick_counter.sv */
// periodic tick generator: period store, step-absent flag and up/down event counter
`include "ptc_params.svh"
`default_nettype none

// What this block does
// - single-bit store samples on clock edge only
// - period store loads all bits when enabled
// - counter load wins over up and down
// - up alone increments count by one
// - down alone decrements count by one
// - no request or both: count holds
// - clear zeroes counter at once, asynchronously
// - width parameter defaults sixteen; count output shown
// - tick one cycle wide per period
// - load presets counter and period store
// - tick reloads counter from stored period
// - step at reload ends countdown at one
// - tick when upper bits and masked lsb zero
// - while loading, counter holds period, step ignored
// - step honoured from first edge after load
// - step reaches tick one cycle later
module ptc_periodic_tick_counter
    import ptc_pkg::*;
#(
    parameter int width_param = `PTC_WIDTH_DEFAULT
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic load,
    input wire logic step,
    input wire logic [width_param-1:0] period,
    output logic tick,
    output logic [width_param-1:0] count,
    output logic [width_param-1:0] period_out,
    output logic running
);

    wire logic [width_param-1:0] period_store_reg;
    wire logic [width_param-1:0] count_reg;
    logic [width_param-1:0] load_value;
    logic step_absent_reg;
    logic step_absent_next;
    logic terminal_nor;
    logic counter_sload;
    logic counter_down;
    ptc_state_t state_reg;
    ptc_state_t state_next;

    // enabled period store, one store per bit
    generate
        for (genvar i = 0; i < width_param; i++) begin : g_store
            ptc_enabled_bit_latch u_bit (
                .clk(clk),
                .rst(rst),
                .ien(load),
                .d(period[i]),
                .q(period_store_reg[i])
            );
        end
    endgenerate

    always_comb begin
        terminal_nor = ~(|count_reg[width_param-1:1] | (count_reg[0] & step_absent_reg));
    end

    always_comb begin
        counter_sload = load | (terminal_nor & (state_reg == PTC_ST_RUN));
        counter_down = step & ~load;
        // reload from store on tick, from input on load
        load_value = load ? period : period_store_reg;
    end

    // event counter; up tied low, so the counter only counts down on step
    ptc_event_counter #(
        .width_param(width_param)
    ) u_counter (
        .clk(clk),
        .rst(rst),
        .clear(clear),
        .sload(counter_sload),
        .up(1'b0),
        .down(counter_down),
        .d(load_value),
        .q(count_reg)
    );

    always_comb begin
        step_absent_next = step_absent_reg;
        if (counter_sload) begin
            step_absent_next = ~(step & ~load);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            step_absent_reg <= `PTC_FLAG_RESET;
        end else begin
            step_absent_reg <= step_absent_next;
        end
    end

    // run from the first clock edge that samples load, whether or not load is released
    always_comb begin
        case (state_reg)
            PTC_ST_IDLE: state_next = load ? PTC_ST_RUN : PTC_ST_IDLE;
            PTC_ST_RUN: state_next = PTC_ST_RUN;
            default: state_next = PTC_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= PTC_ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_comb begin
        tick = terminal_nor & ~load & (state_reg == PTC_ST_RUN);
    end

    always_comb begin
        count = count_reg;
        period_out = period_store_reg;
        running = (state_reg == PTC_ST_RUN);
    end

endmodule

// single-bit store: the held value is fed back so the clock is never gated
module ptc_enabled_bit_latch (
    input wire logic clk,
    input wire logic rst,
    input wire logic ien,
    input wire logic d,
    output logic q
);

    logic q_reg;
    logic q_next;

    // hold value fed back through the mux
    always_comb begin
        q_next = ien ? d : q_reg;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q_reg <= 1'b0;
        end else begin
            q_reg <= q_next;
        end
    end

    always_comb begin
        q = q_reg;
    end

endmodule

// up/down event counter with synchronous load and asynchronous clear
module ptc_event_counter
    import ptc_pkg::*;
#(
    parameter int width_param = `PTC_WIDTH_DEFAULT
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic sload,
    input wire logic up,
    input wire logic down,
    input wire logic [width_param-1:0] d,
    output logic [width_param-1:0] q
);

    // load wins, then a lone up or a lone down, otherwise hold
    function automatic ptc_op_t ptc_decode(input logic ld, input logic inc, input logic dec);
        if (ld) begin
            return PTC_OP_LOAD;
        end else if (inc && !dec) begin
            return PTC_OP_UP;
        end else if (dec && !inc) begin
            return PTC_OP_DOWN;
        end else begin
            return PTC_OP_HOLD;
        end
    endfunction

    logic [width_param-1:0] count_reg;
    logic [width_param-1:0] count_next;
    ptc_op_t op;

    always_comb begin
        op = ptc_decode(sload, up, down);
    end

    always_comb begin
        case (op)
            PTC_OP_LOAD: count_next = d;
            PTC_OP_UP: count_next = count_reg + {{(width_param-1){1'b0}}, 1'b1};
            PTC_OP_DOWN: count_next = count_reg - {{(width_param-1){1'b0}}, 1'b1};
            PTC_OP_HOLD: count_next = count_reg;
            default: count_next = count_reg;
        endcase
    end

    always_ff @(posedge clk or posedge rst or posedge clear) begin
        if (rst || clear) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    always_comb begin
        q = count_reg;
    end

endmodule
`default_nettype wire

/* verif/ptc_periodic_tick_counter_chk.sv */
// assertion checker for the periodic tick counter
`default_nettype none
module ptc_periodic_tick_counter_chk #(parameter int width_param = 16) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic load,
    input wire logic step,
    input wire logic [width_param-1:0] period,
    input wire logic tick,
    input wire logic [width_param-1:0] count,
    input wire logic [width_param-1:0] period_out,
    input wire logic running
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    ld_store_a: assert property (load |=> period_out == $past(period)) else $error("store");
    ld_count_a: assert property (load && !clear ##1 !clear |-> count == $past(period)) else $error("preset");
    clr_zero_a: assert property (clear |-> count == 0) else $error("clear");
    ld_quiet_a: assert property (load |-> !tick) else $error("quiet");
    tick_reload_a: assert property (tick && !clear ##1 !clear |-> count == $past(period_out)) else $error("reload");
    tick_width_a: assert property (tick && !clear ##1 !clear |-> !tick) else $error("width");
    step_dec_a: assert property (step && !load && !tick && !clear ##1 !clear |-> count == $past(count) - 1'b1)
        else $error("step");
    idle_hold_a: assert property (!step && !load && !tick && !clear ##1 !clear |-> $stable(count))
        else $error("hold");
endmodule
bind ptc_periodic_tick_counter ptc_periodic_tick_counter_chk #(.width_param(width_param)) chk_i (.clk(clk),
    .rst(rst), .clear(clear), .load(load), .step(step), .period(period), .tick(tick), .count(count),
    .period_out(period_out), .running(running));
`default_nettype wire

/* verif/ptc_feeder.sv */
// event source standing in for the control logic around the counter
`default_nettype none
module ptc_feeder (
    input wire logic clk,
    input wire logic en,
    output var logic load,
    output var logic step,
    output var logic clear,
    output var logic [15:0] period
);
    timeunit 1ns;
    timeprecision 1ps;
    bit first = 1;
    int r;
    initial {load, step, clear, period} = '0;
    always @(negedge clk) if (en) begin
        r = $urandom % 64;
        load = first || r < 3;
        clear = r == 5;
        step = r > 20;
        period = 16'(2 + $urandom % 14);
        first = 0;
    end
endmodule
`default_nettype wire

/* verif/test_periodic_tick_counter.sv */
// self-checking bench for the periodic tick counter
`default_nettype none
module test_periodic_tick_counter;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, en = 0, load, step, clear, tick, running;
    logic [15:0] period, count, period_out;
    int n_fail = 0, n_tests = 0, cyc = 0, m_cnt = 0, m_per = 0, m_flag = 1, m_run = 0;
    bit m_tick;
    ptc_periodic_tick_counter dut (.clk(clk), .rst(rst), .clear(clear), .load(load), .step(step),
        .period(period), .tick(tick), .count(count), .period_out(period_out), .running(running));
    ptc_feeder feed (.clk(clk), .en(en), .load(load), .step(step), .clear(clear), .period(period));
    initial forever #2.5 clk = ~clk;
    task chk(string n, logic [15:0] e, logic [15:0] g);
        n_tests++;
        if (e !== g) begin
            n_fail++;
            $display("Error %s exp %h got %h", n, e, g);
        end
    endtask
    task finish_test;
        $display("tests %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk) if (!rst) begin
        if (clear) m_cnt = 0;
        m_tick = m_run && !load && m_cnt < 2 && !(m_cnt == 1 && m_flag);
        chk("tick", 16'(m_tick), 16'(tick));
        chk("count", 16'(m_cnt), count);
        chk("period_out", 16'(m_per), period_out);
        if (load) begin
            m_cnt = period;
            m_per = period;
            m_flag = 1;
            m_run = 1;
        end else if (m_tick) begin
            m_cnt = m_per;
            m_flag = !step;
        end else if (step) m_cnt = m_cnt - 1;
        if (clear) m_cnt = 0;
    end
    initial begin
        void'($urandom(63));
        repeat (12) @(posedge clk);
        @(negedge clk) rst = 0;
        en = 1;
        repeat (3000) @(posedge clk);
        finish_test;
    end
    always @(posedge clk) if (++cyc > 4000) begin
        n_fail++;
        finish_test;
    end
endmodule
`default_nettype wire
